//--- logic/analog_trend_poll_manager.sv
// Analog trend poll manager: keeps up to ten current-loop points under periodic acquisition.
// Assumes requests, point status and panel network answers come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1 - Requests naming more than ten points get an exception answer.
// RULE2 - Any named point that is not a current-loop module gives an exception.
// RULE3 - First request for a set initializes it; acquisition then runs every 5 seconds.
// RULE4 - The initializing request is answered with zero for every point.
// RULE5 - Fetch only points at first alarm level or above; normal points read zero.
// RULE6 - Each stored value is refreshed at most once per 5 seconds.
// RULE7 - A point back in normal state is not fetched and its value is zeroed.
// RULE8 - Acquisition stops when the exact set is not requested within the idle timeout.
// RULE9 - A different set is confirmed as an initialization and then acquired every 5 seconds.
// RULE10 - A faulted current-loop module has its stored value cleared to zero.
// RULE11 - Overlapping points keep real values, dropped points stop, new points start.
// RULE12 - Only points of the latest valid request are acquired.
// RULE13 - Client should wait 5 seconds after initializing before expecting real values.
// RULE14 - Client reads more than ten points as separate sets of at most ten.
// RULE15 - Values are 16-bit registers, one per point address.
// RULE16 - A request for exactly the active set restarts the idle timeout.
module analog_trend_poll_manager #(
  parameter int CYCLES_PER_S = trend_pkg::CYCLES_PER_S
) (
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Client request and answer.
  input wire logic req_valid,
  input wire trend_pkg::trend_req_t req,
  output logic resp_valid,
  output trend_pkg::trend_resp_t resp,
  // Configuration.
  input wire logic [trend_pkg::SEC_W-1:0] timeout_s,
  // Acquisition set and status of its points, indexed by slot.
  output logic [trend_pkg::NUM_PTS-1:0] slot_active,
  output logic [trend_pkg::NUM_PTS-1:0][trend_pkg::ADDR_W-1:0] slot_addr,
  input wire logic [trend_pkg::NUM_PTS-1:0] slot_alarm,
  input wire logic [trend_pkg::NUM_PTS-1:0] slot_fault,
  // Panel network fetch port.
  output logic net_req_valid,
  output logic [trend_pkg::ADDR_W-1:0] net_addr,
  input wire logic net_rsp_valid,
  input wire logic [trend_pkg::VAL_W-1:0] net_value
);

  typedef struct packed {
    logic [trend_pkg::NUM_PTS-1:0] act;
    logic [trend_pkg::NUM_PTS-1:0][trend_pkg::ADDR_W-1:0] addr;
    logic [trend_pkg::NUM_PTS-1:0][trend_pkg::VAL_W-1:0] val;
    logic [trend_pkg::PRE_W-1:0] pre;
    logic [trend_pkg::SEC_W-1:0] poll_s;
    logic [trend_pkg::SEC_W-1:0] idle_s;
    logic pass_pend;
    trend_pkg::seq_state_t seq;
    logic [trend_pkg::IDX_W-1:0] idx;
    logic net_req_valid;
    logic [trend_pkg::ADDR_W-1:0] net_addr;
    logic resp_valid;
    trend_pkg::trend_resp_t resp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  localparam logic [trend_pkg::PRE_W-1:0] PRE_LAST = trend_pkg::PRE_W'(CYCLES_PER_S - 1);
  localparam logic [trend_pkg::IDX_W-1:0] IDX_END = trend_pkg::IDX_W'(trend_pkg::NUM_PTS);
  localparam logic [trend_pkg::CNT_W-1:0] CNT_MAX = trend_pkg::CNT_W'(trend_pkg::NUM_PTS);

  // Next-state logic; later steps override earlier ones, so a request wins over housekeeping.
  always_comb
  begin
    logic sec_tick;
    logic bad;
    logic exact;
    logic hit;
    logic [trend_pkg::VAL_W-1:0] keep;
    logic [trend_pkg::NUM_PTS-1:0] new_act;
    logic [trend_pkg::NUM_PTS-1:0][trend_pkg::VAL_W-1:0] cur_val;
    st_nxt = st_r;
    sec_tick = 1'b0;
    bad = 1'b0;
    exact = 1'b0;
    hit = 1'b0;
    keep = trend_pkg::ZERO_VAL;
    new_act = '0;
    cur_val = '0;
    st_nxt.net_req_valid = 1'b0;
    st_nxt.resp_valid = 1'b0;

    // One-second prescaler shared by the poll interval and the idle timeout.
    if (st_r.pre == PRE_LAST)
    begin
      st_nxt.pre = '0;
      sec_tick = 1'b1;
    end
    else
    begin
      st_nxt.pre = st_r.pre + 1'b1;
    end

    // Points that are normal or faulted hold zero; this also drops stale values.
    for (int i = 0; i < trend_pkg::NUM_PTS; i++)
    begin
      if (!st_r.act[i] || !slot_alarm[i] || slot_fault[i])
      begin
        st_nxt.val[i] = trend_pkg::ZERO_VAL; // RULE5 RULE7 RULE10
      end
    end

    // Acquisition pass: one start every five seconds, so no value refreshes faster.
    if (sec_tick && (st_r.act != '0))
    begin
      if (st_r.poll_s >= trend_pkg::POLL_INTERVAL_S - 8'h01)
      begin
        st_nxt.poll_s = '0;
        st_nxt.pass_pend = 1'b1; // RULE3 RULE6
      end
      else
      begin
        st_nxt.poll_s = st_r.poll_s + 8'h01;
      end
    end

    case (st_r.seq)
      trend_pkg::SEQ_IDLE:
      begin
        if (st_r.pass_pend)
        begin
          st_nxt.pass_pend = 1'b0;
          st_nxt.idx = '0;
          st_nxt.seq = trend_pkg::SEQ_ISSUE;
        end
      end
      trend_pkg::SEQ_ISSUE:
      begin
        if (st_r.idx >= IDX_END)
        begin
          st_nxt.seq = trend_pkg::SEQ_IDLE;
        end
        else if (st_r.act[st_r.idx] && slot_alarm[st_r.idx] && !slot_fault[st_r.idx])
        begin
          st_nxt.net_req_valid = 1'b1; // RULE5 RULE12
          st_nxt.net_addr = st_r.addr[st_r.idx];
          st_nxt.seq = trend_pkg::SEQ_WAIT;
        end
        else
        begin
          st_nxt.idx = st_r.idx + 1'b1;
        end
      end
      trend_pkg::SEQ_WAIT:
      begin
        if (net_rsp_valid)
        begin
          // The set may have been reshuffled while waiting, so match by address.
          for (int i = 0; i < trend_pkg::NUM_PTS; i++)
          begin
            if (st_r.act[i] && st_r.addr[i] == st_r.net_addr && slot_alarm[i] && !slot_fault[i])
            begin
              st_nxt.val[i] = net_value;
            end
          end
          st_nxt.idx = st_r.idx + 1'b1;
          st_nxt.seq = trend_pkg::SEQ_ISSUE;
        end
      end
      default:
      begin
        st_nxt.seq = trend_pkg::SEQ_IDLE;
      end
    endcase

    // Idle timeout counted in whole seconds while a set is active.
    if (sec_tick && (st_r.act != '0))
    begin
      if (st_r.idle_s + 8'h01 >= timeout_s)
      begin
        st_nxt.act = '0; // RULE8
        st_nxt.idle_s = '0;
        st_nxt.poll_s = '0;
        st_nxt.pass_pend = 1'b0;
      end
      else
      begin
        st_nxt.idle_s = st_r.idle_s + 8'h01;
      end
    end

    // Request handling.
    if (req_valid)
    begin
      st_nxt.resp_valid = 1'b1;
      st_nxt.resp.data = '0;
      if (req.count > CNT_MAX || req.count == '0)
      begin
        bad = 1'b1; // RULE1
      end
      for (int i = 0; i < trend_pkg::NUM_PTS; i++)
      begin
        if (trend_pkg::CNT_W'(i) < req.count && !req.is_loop[i])
        begin
          bad = 1'b1; // RULE2
        end
      end
      st_nxt.resp.exception = bad;
      if (!bad)
      begin
        exact = 1'b1;
        for (int i = 0; i < trend_pkg::NUM_PTS; i++)
        begin
          new_act[i] = trend_pkg::CNT_W'(i) < req.count;
        end
        if (new_act != st_r.act)
        begin
          exact = 1'b0;
        end
        // Snapshot taken before any slot is rewritten, so a point that moves to a later slot
        // still finds its own value rather than one already overwritten by this request.
        cur_val = st_nxt.val;
        for (int i = 0; i < trend_pkg::NUM_PTS; i++)
        begin
          hit = 1'b0;
          keep = trend_pkg::ZERO_VAL;
          for (int j = 0; j < trend_pkg::NUM_PTS; j++)
          begin
            if (st_r.act[j] && st_r.addr[j] == req.addr[i])
            begin
              hit = 1'b1;
              keep = cur_val[j]; // RULE11
            end
          end
          if (new_act[i])
          begin
            if (!hit)
            begin
              exact = 1'b0;
            end
            // New points start at zero; points already acquired keep real values.
            st_nxt.resp.data[i] = keep; // RULE4 RULE9 RULE11 RULE15
            st_nxt.val[i] = keep;
            st_nxt.addr[i] = req.addr[i];
          end
          else
          begin
            st_nxt.val[i] = trend_pkg::ZERO_VAL;
            st_nxt.addr[i] = '0;
          end
        end
        st_nxt.act = new_act; // RULE12
        st_nxt.idle_s = '0; // RULE16
        if (!exact)
        begin
          // A changed set restarts the five-second cadence from this request.
          st_nxt.poll_s = '0; // RULE9
        end
      end
    end

    // A fetch chosen from a set that changes in this same cycle is withdrawn and retried,
    // so the panel network never sees an address that the new set no longer holds.
    if (st_r.seq == trend_pkg::SEQ_ISSUE &&
        (st_nxt.act != st_r.act || st_nxt.addr != st_r.addr))
    begin
      st_nxt.net_req_valid = 1'b0; // RULE12
      st_nxt.net_addr = st_r.net_addr;
      st_nxt.idx = st_r.idx;
      st_nxt.seq = trend_pkg::SEQ_ISSUE;
    end
  end

  // State register; the enable freezes everything while low.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign resp_valid = st_r.resp_valid;
  assign resp = st_r.resp;
  assign slot_active = st_r.act;
  assign slot_addr = st_r.addr;
  assign net_req_valid = st_r.net_req_valid;
  assign net_addr = st_r.net_addr;

endmodule : analog_trend_poll_manager
`default_nettype wire

//--- common/trend_pkg.sv
// Shared constants and carriers for the analog trend poll manager.
// Assumes a single 100 MHz clock domain and a request port fed by protocol logic.
package trend_pkg;
  localparam int NUM_PTS = 10;
  localparam int ADDR_W = 16;
  localparam int VAL_W = 16;
  localparam int CNT_W = 8;
  localparam int IDX_W = 4;
  localparam int SEC_W = 8;
  localparam int PRE_W = 27;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_S = 1000000000;
  // Cycles in one second at the clock rate.
  localparam int CYCLES_PER_S = NS_PER_S / CLK_PERIOD_NS;
  localparam logic [SEC_W-1:0] POLL_INTERVAL_S = 8'h05;
  localparam logic [SEC_W-1:0] DEFAULT_TIMEOUT_S = 8'h14;
  localparam logic [VAL_W-1:0] ZERO_VAL = 16'h0000;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_t;

  // One analog value request from the client side.
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [NUM_PTS-1:0][ADDR_W-1:0] addr;
    logic [NUM_PTS-1:0] is_loop;
  } trend_req_t;

  // Answer to one request.
  typedef struct packed {
    logic exception;
    logic [NUM_PTS-1:0][VAL_W-1:0] data;
  } trend_resp_t;
endpackage : trend_pkg

//--- dv/panel_net_model.sv
// Panel network model: answers each fetch with a value derived from the address.
// Assumes one fetch outstanding at a time, on the design clock.
`timescale 1ns/1ps
`default_nettype none
module panel_net_model (
  // Clock, reset and answer pace.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  // Fetch port.
  input wire logic net_req_valid,
  input wire logic [15:0] net_addr,
  output logic net_rsp_valid,
  output logic [15:0] net_value
);
  localparam logic [15:0] KEY = 16'hA5A5;
  int wait_c;
  logic [15:0] addr_q;
  // Between answers the data line toggles, so a stale value is never taken for an answer.
  always @(posedge mclk or negedge rst_n)
  begin
    net_rsp_valid <= 1'b0;
    net_value <= ~net_value;
    if (!rst_n)
    begin
      wait_c <= 0;
      net_value <= 16'h0000;
    end
    else if (net_req_valid)
    begin
      addr_q <= net_addr;
      wait_c <= slow ? 7 : 2;
    end
    else if (wait_c == 1)
    begin
      net_rsp_valid <= 1'b1;
      net_value <= addr_q ^ KEY;
      wait_c <= 0;
    end
    else if (wait_c > 1)
      wait_c <= wait_c - 1;
  end
endmodule : panel_net_model
`default_nettype wire

//--- dv/analog_trend_poll_manager_asserts.sv
// Checker for the poll manager, bound to its ports.
// Assumes one clock domain with the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module analog_trend_poll_manager_asserts (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Client side.
  input wire logic ce,
  input wire logic req_valid,
  input wire trend_pkg::trend_req_t req,
  input wire logic resp_valid,
  input wire trend_pkg::trend_resp_t resp,
  // Acquisition side.
  input wire logic [trend_pkg::NUM_PTS-1:0] slot_active,
  input wire logic [trend_pkg::NUM_PTS-1:0][trend_pkg::ADDR_W-1:0] slot_addr,
  input wire logic net_req_valid,
  input wire logic [trend_pkg::ADDR_W-1:0] net_addr
);
  logic take;
  logic hit;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A fetch must name a slot of the active set.
  always_comb
  begin
    take = ce & req_valid;
    hit = 1'b0;
    for (int i = 0; i < trend_pkg::NUM_PTS; i++)
      hit = hit | (slot_active[i] & (slot_addr[i] == net_addr));
  end
  property p_resp; take |=> resp_valid; endproperty
  a_resp: assert property (p_resp) else $error("no answer");
  property p_over; take && req.count > 8'h0A |=> resp.exception && resp.data == '0; endproperty
  a_over: assert property (p_over) else $error("oversize accepted");
  property p_loop; take && req.count == 8'h01 && !req.is_loop[0] |=> resp.exception; endproperty
  a_loop: assert property (p_loop) else $error("non-loop accepted");
  property p_keep; take && req.count > 8'h0A |=> $stable(slot_active); endproperty
  a_keep: assert property (p_keep) else $error("set changed on refusal");
  property p_init; take && slot_active == '0 |=> resp.data == '0; endproperty
  a_init: assert property (p_init) else $error("init not zero");
  property p_fetch; net_req_valid |-> hit; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch outside set");
  property p_pulse; net_req_valid |=> !net_req_valid [*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch too soon");
  property p_drop; $changed(slot_active) && !$past(req_valid) |-> slot_active == '0; endproperty
  a_drop: assert property (p_drop) else $error("set changed unasked");
  c_over: cover property (take && req.count > 8'h0A);
  c_fetch: cover property (net_req_valid);
  c_drop: cover property ($fell(|slot_active));
endmodule : analog_trend_poll_manager_asserts
bind analog_trend_poll_manager analog_trend_poll_manager_asserts chk (.mclk(mclk),
  .rst_n(rst_n), .ce(ce), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
  .resp(resp), .slot_active(slot_active), .slot_addr(slot_addr),
  .net_req_valid(net_req_valid), .net_addr(net_addr));
`default_nettype wire

//--- dv/tb_analog_trend_poll_manager.sv
// Testbench for the poll manager: client requests, point status and a network model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; \
  if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_analog_trend_poll_manager;
  localparam int CPS = 20;
  localparam logic [15:0] KEY = 16'hA5A5;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic slow = 1'b0;
  logic [7:0] timeout_s = trend_pkg::DEFAULT_TIMEOUT_S;
  logic [15:0] norm_a = 16'h0102;
  logic [15:0] flt_a = 16'h0103;
  trend_pkg::trend_req_t req = '0;
  trend_pkg::trend_resp_t resp, rsp;
  logic resp_valid, net_req_valid, net_rsp_valid;
  logic [9:0] slot_active, slot_alarm, slot_fault;
  logic [9:0][15:0] slot_addr;
  logic [15:0] net_addr, net_value;
  int fails = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  // Point status follows the slot address, so slot placement inside the block does not matter.
  always_comb
    for (int s = 0; s < 10; s++)
    begin
      slot_alarm[s] = slot_addr[s] != norm_a;
      slot_fault[s] = slot_addr[s] == flt_a;
    end
  analog_trend_poll_manager #(.CYCLES_PER_S(CPS)) dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .req_valid(req_valid), .req(req), .resp_valid(resp_valid), .resp(resp),
    .timeout_s(timeout_s), .slot_active(slot_active), .slot_addr(slot_addr),
    .slot_alarm(slot_alarm), .slot_fault(slot_fault), .net_req_valid(net_req_valid),
    .net_addr(net_addr), .net_rsp_valid(net_rsp_valid), .net_value(net_value));
  panel_net_model net (.mclk(mclk), .rst_n(rst_n), .slow(slow), .net_req_valid(net_req_valid),
    .net_addr(net_addr), .net_rsp_valid(net_rsp_valid), .net_value(net_value));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // One request of n points at base..base+n-1; the answer is caught within a bounded wait.
  task automatic send(input int n, input logic [15:0] base, input logic [9:0] lp);
    int k;
    @(negedge mclk);
    req.count = n[7:0];
    req.is_loop = lp;
    for (int i = 0; i < 10; i++)
      req.addr[i] = base + 16'(i);
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 3)
    begin
      @(negedge mclk);
      k++;
    end
    rsp = resp;
    `CHK("resp_valid", 1'b1, resp_valid)
  endtask : send
  task automatic check_vals(input logic [15:0] base, input int n, input logic [9:0] m);
    for (int i = 0; i < n; i++)
      `CHK("data", m[i] ? (base + 16'(i)) ^ KEY : 16'h0000, rsp.data[i])
  endtask : check_vals
  task automatic t_refuse;
    send(11, 16'h0100, 10'h3FF);
    `CHK("exc_count", 1'b1, rsp.exception)
    `CHK("exc_data", '0, rsp.data)
    send(3, 16'h0100, 10'h3FB);
    `CHK("exc_loop", 1'b1, rsp.exception)
    send(1, 16'h0100, 10'h3FE);
    `CHK("exc_one", 1'b1, rsp.exception)
    `CHK("set_kept", 10'h000, slot_active)
  endtask : t_refuse
  task automatic t_init;
    send(10, 16'h0100, 10'h3FF);
    `CHK("init_exc", 1'b0, rsp.exception)
    `CHK("init_zero", '0, rsp.data)
    repeat (12 * CPS) @(negedge mclk);
    send(10, 16'h0100, 10'h3FF);
    check_vals(16'h0100, 10, 10'h3F3);
  endtask : t_init
  task automatic t_overlap;
    send(8, 16'h0105, 10'h0FF);
    check_vals(16'h0105, 8, 10'h01F);
    `CHK("set_size", 4'h8, 4'($countones(slot_active)))
    norm_a = 16'h0106;
    slow = 1'b1;
    repeat (12 * CPS) @(negedge mclk);
    send(8, 16'h0105, 10'h0FF);
    check_vals(16'h0105, 8, 10'h0FD);
    // Shifting the set down one address moves every kept point to a later slot.
    send(8, 16'h0104, 10'h0FF);
    check_vals(16'h0104, 8, 10'h0FA);
  endtask : t_overlap
  task automatic t_new_idle;
    send(3, 16'h0200, 10'h007);
    `CHK("new_zero", '0, rsp.data)
    timeout_s = 8'h04;
    repeat (5)
    begin
      repeat (2 * CPS) @(negedge mclk);
      send(3, 16'h0200, 10'h007);
    end
    check_vals(16'h0200, 3, 10'h007);
    `CHK("kept", 4'h3, 4'($countones(slot_active)))
    repeat (8 * CPS) @(negedge mclk);
    `CHK("dropped", 10'h000, slot_active)
  endtask : t_new_idle
  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    t_refuse();
    t_init();
    t_overlap();
    t_new_idle();
    finish_test();
  end
  // Watchdog: about twice the expected run length.
  initial
  begin
    repeat (100 * CPS) @(posedge mclk);
    fails++;
    finish_test();
  end
endmodule : tb_analog_trend_poll_manager
`default_nettype wire
